//--- core/xy_plotter_pkg.sv
package xy_plotter_pkg;

  // converter widths
  localparam int unsigned Y_WIDTH = 10;
  localparam int unsigned X_WIDTH = 10;

  // values after reset
  localparam logic [Y_WIDTH-1:0] Y_RESET_CODE = 10'h000;
  localparam logic [X_WIDTH-1:0] X_RESET_CODE = 10'h000;

  // end-of-travel flags after reset: the counter starts at the far left
  localparam logic X_AT_LEFT_RESET  = 1'h1;
  localparam logic X_AT_RIGHT_RESET = 1'h0;

  // horizontal end points of the plot
  localparam logic [X_WIDTH-1:0] X_LEFT_CODE  = 10'h000;
  localparam logic [X_WIDTH-1:0] X_RIGHT_CODE = 10'h3FF;

  // one counting step
  localparam logic [X_WIDTH-1:0] X_STEP = 10'h001;

  // positions of the strobes in the synchroniser bank
  localparam int unsigned CMD_COUNT        = 5;
  localparam int unsigned CMD_Y_STROBE     = 0;
  localparam int unsigned CMD_X_UP         = 1;
  localparam int unsigned CMD_X_DOWN       = 2;
  localparam int unsigned CMD_X_PRESET     = 3;
  localparam int unsigned CMD_X_CLEAR      = 4;

  // strobe levels after reset (idle, deasserted)
  localparam logic CMD_IDLE_LEVEL = 1'b0;

  // sync chain depth before a level is believed
  localparam int unsigned SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    X_OP_HOLD   = 3'h0,
    X_OP_UP     = 3'h1,
    X_OP_DOWN   = 3'h2,
    X_OP_PRESET = 3'h3,
    X_OP_CLEAR  = 3'h4
  } x_op_t;

endpackage : xy_plotter_pkg

//--- core/cmd_edge_sync.sv
`timescale 1ns/1ps
module cmd_edge_sync (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // asynchronous strobe from the driver board
  input  wire logic strobe_raw,
  // qualified level and its rising edge
  output logic      strobe_level,
  output logic      strobe_rise
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;
  logic level_next;

  // stage1 feeds stage2 only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stage1_reg <= xy_plotter_pkg::CMD_IDLE_LEVEL;
      stage2_reg <= xy_plotter_pkg::CMD_IDLE_LEVEL;
      stage3_reg <= xy_plotter_pkg::CMD_IDLE_LEVEL;
    end else begin
      stage1_reg <= strobe_raw;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // a change counts only once two stages agree, so a one-cycle glitch is dropped
  always_comb begin
    level_next = strobe_level;
    if (stage2_reg == stage3_reg) begin
      level_next = stage3_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      strobe_level <= xy_plotter_pkg::CMD_IDLE_LEVEL;
      strobe_rise  <= 1'b0;
    end else begin
      strobe_level <= level_next;
      strobe_rise  <= level_next & ~strobe_level;
    end
  end

endmodule : cmd_edge_sync

//--- core/xy_plotter_axis_drive.sv
`timescale 1ns/1ps
// Behaviour
// R1 - latch each vertical word, hold until next
// R2 - step-up command increments 10-bit horizontal counter
// R3 - step-down command decrements horizontal counter
// R4 - preset command loads far-right position
// R5 - return-left command clears counter to far left
// R6 - counter drives horizontal converter continuously
// R7 - preset all ones; clear beats preset beats count
module xy_plotter_axis_drive (
  // clock and reset
  input  wire logic                                 core_clk,
  input  wire logic                                 srst,
  // vertical data from the display driver
  input  wire logic [xy_plotter_pkg::Y_WIDTH-1:0]   y_word,
  input  wire logic                                 y_strobe,
  // horizontal commands from the display driver
  input  wire logic                                 x_step_up,
  input  wire logic                                 x_step_down,
  input  wire logic                                 x_preset_full,
  input  wire logic                                 x_return_left,
  // converter inputs
  output logic      [xy_plotter_pkg::Y_WIDTH-1:0]   y_dac_code,
  output logic      [xy_plotter_pkg::X_WIDTH-1:0]   x_dac_code,
  // status
  output logic                                      y_update,
  output logic                                      x_update,
  output logic                                      x_at_left,
  output logic                                      x_at_right
);

  // raw and qualified strobes
  logic [xy_plotter_pkg::CMD_COUNT-1:0] cmd_async;
  logic [xy_plotter_pkg::CMD_COUNT-1:0] cmd_rise;

  // vertical word stages and its settled copy
  logic [xy_plotter_pkg::Y_WIDTH-1:0]   y_word_s1_reg;
  logic [xy_plotter_pkg::Y_WIDTH-1:0]   y_word_s2_reg;
  logic [xy_plotter_pkg::Y_WIDTH-1:0]   y_word_s3_reg;
  logic [xy_plotter_pkg::Y_WIDTH-1:0]   y_word_q_reg;

  // horizontal position
  logic [xy_plotter_pkg::X_WIDTH-1:0]   x_count_reg;
  logic [xy_plotter_pkg::X_WIDTH-1:0]   x_count_next;
  xy_plotter_pkg::x_op_t                x_op;

  // resolve coincident commands into one operation;
  // up and down on the same edge cancel rather than pick a winner
  function automatic xy_plotter_pkg::x_op_t pick_op(
    input logic up,
    input logic down,
    input logic preset,
    input logic clear
  );
    xy_plotter_pkg::x_op_t op;
    op = xy_plotter_pkg::X_OP_HOLD;
    if (clear) begin
      op = xy_plotter_pkg::X_OP_CLEAR; // R7
    end else if (preset) begin
      op = xy_plotter_pkg::X_OP_PRESET; // R7
    end else if (up && !down) begin
      op = xy_plotter_pkg::X_OP_UP;
    end else if (down && !up) begin
      op = xy_plotter_pkg::X_OP_DOWN;
    end
    return op;
  endfunction : pick_op

  // next counter value for an operation
  function automatic logic [xy_plotter_pkg::X_WIDTH-1:0] apply_op(
    input xy_plotter_pkg::x_op_t              op,
    input logic [xy_plotter_pkg::X_WIDTH-1:0] count
  );
    logic [xy_plotter_pkg::X_WIDTH-1:0] result;
    result = count;
    case (op)
      xy_plotter_pkg::X_OP_UP: begin
        result = count + xy_plotter_pkg::X_STEP; // R2
      end
      xy_plotter_pkg::X_OP_DOWN: begin
        result = count - xy_plotter_pkg::X_STEP; // R3
      end
      xy_plotter_pkg::X_OP_PRESET: begin
        result = xy_plotter_pkg::X_RIGHT_CODE; // R4
      end
      xy_plotter_pkg::X_OP_CLEAR: begin
        result = xy_plotter_pkg::X_LEFT_CODE; // R5
      end
      default: begin
        result = count;
      end
    endcase
    return result;
  endfunction : apply_op

  // per bit: take the stage value where two stages agree, else keep the old bit
  function automatic logic [xy_plotter_pkg::Y_WIDTH-1:0] settle_bits(
    input logic [xy_plotter_pkg::Y_WIDTH-1:0] older,
    input logic [xy_plotter_pkg::Y_WIDTH-1:0] newer,
    input logic [xy_plotter_pkg::Y_WIDTH-1:0] held
  );
    logic [xy_plotter_pkg::Y_WIDTH-1:0] agree;
    agree = ~(older ^ newer);
    return (older & agree) | (held & ~agree);
  endfunction : settle_bits

  assign cmd_async[xy_plotter_pkg::CMD_Y_STROBE] = y_strobe;
  assign cmd_async[xy_plotter_pkg::CMD_X_UP]     = x_step_up;
  assign cmd_async[xy_plotter_pkg::CMD_X_DOWN]   = x_step_down;
  assign cmd_async[xy_plotter_pkg::CMD_X_PRESET] = x_preset_full;
  assign cmd_async[xy_plotter_pkg::CMD_X_CLEAR]  = x_return_left;

  // each strobe crosses from the driver board on its own chain
  genvar gi;
  generate
    for (gi = 0; gi < xy_plotter_pkg::CMD_COUNT; gi++) begin : g_sync
      cmd_edge_sync u_sync (
        .core_clk     (core_clk),
        .srst         (srst),
        .strobe_raw   (cmd_async[gi]),
        .strobe_level (),
        .strobe_rise  (cmd_rise[gi])
      );
    end
  endgenerate

  // data word passes the same three stages as the strobes; word must be
  // stable from before the strobe until five clocks after it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      y_word_s1_reg <= xy_plotter_pkg::Y_RESET_CODE;
      y_word_s2_reg <= xy_plotter_pkg::Y_RESET_CODE;
      y_word_s3_reg <= xy_plotter_pkg::Y_RESET_CODE;
    end else begin
      y_word_s1_reg <= y_word;
      y_word_s2_reg <= y_word_s1_reg;
      y_word_s3_reg <= y_word_s2_reg;
    end
  end

  // a bit moves only where two stages agree, so one caught mid-change keeps
  // its settled level rather than a half-resolved one
  always_ff @(posedge core_clk) begin
    if (srst) begin
      y_word_q_reg <= xy_plotter_pkg::Y_RESET_CODE;
    end else begin
      y_word_q_reg <= settle_bits(y_word_s3_reg, y_word_s2_reg, y_word_q_reg);
    end
  end

  // vertical holding latch
  always_ff @(posedge core_clk) begin
    if (srst) begin
      y_dac_code <= xy_plotter_pkg::Y_RESET_CODE;
    end else if (cmd_rise[xy_plotter_pkg::CMD_Y_STROBE]) begin
      y_dac_code <= y_word_q_reg; // R1
    end
  end

  // one-clock marker in the cycle the converter takes a new word
  always_ff @(posedge core_clk) begin
    if (srst) begin
      y_update <= 1'b0;
    end else begin
      y_update <= cmd_rise[xy_plotter_pkg::CMD_Y_STROBE];
    end
  end

  // one operation per qualified edge; a held command acts once only
  always_comb begin
    x_op = pick_op(cmd_rise[xy_plotter_pkg::CMD_X_UP],
                   cmd_rise[xy_plotter_pkg::CMD_X_DOWN],
                   cmd_rise[xy_plotter_pkg::CMD_X_PRESET],
                   cmd_rise[xy_plotter_pkg::CMD_X_CLEAR]);
    x_count_next = apply_op(x_op, x_count_reg);
  end

  // cascade counter wraps at the ends, as the ripple chain would;
  // no stop at the ends: preset and clear are the only way to park the pen
  always_ff @(posedge core_clk) begin
    if (srst) begin
      x_count_reg <= xy_plotter_pkg::X_RESET_CODE;
    end else begin
      x_count_reg <= x_count_next; // R2 R3 R4 R5
    end
  end

  // converter code leaves a flop, one clock behind the counter
  always_ff @(posedge core_clk) begin
    if (srst) begin
      x_dac_code <= xy_plotter_pkg::X_RESET_CODE;
    end else begin
      x_dac_code <= x_count_reg; // R6
    end
  end

  // marks the cycle in which the converter code moved; a command that
  // leaves the count where it was raises no marker
  always_ff @(posedge core_clk) begin
    if (srst) begin
      x_update <= 1'b0;
    end else begin
      x_update <= (x_dac_code != x_count_reg);
    end
  end

  // end-of-travel flags change together with the converter code
  always_ff @(posedge core_clk) begin
    if (srst) begin
      x_at_left <= xy_plotter_pkg::X_AT_LEFT_RESET;
    end else begin
      x_at_left <= (x_count_reg == xy_plotter_pkg::X_LEFT_CODE);
    end
  end

  // far-right flag, same timing as the far-left one
  always_ff @(posedge core_clk) begin
    if (srst) begin
      x_at_right <= xy_plotter_pkg::X_AT_RIGHT_RESET;
    end else begin
      x_at_right <= (x_count_reg == xy_plotter_pkg::X_RIGHT_CODE);
    end
  end

endmodule : xy_plotter_axis_drive

//--- verification/xy_plotter_axis_drive_monitor.sv
`timescale 1ns/1ps
module xy_plotter_axis_drive_monitor (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       srst,
  // driver board side
  input wire logic [9:0] y_word,
  input wire logic       y_strobe,
  input wire logic       x_step_up,
  input wire logic       x_step_down,
  input wire logic       x_preset_full,
  input wire logic       x_return_left,
  // converter side
  input wire logic [9:0] y_dac_code,
  input wire logic [9:0] x_dac_code,
  input wire logic       y_update,
  input wire logic       x_update,
  input wire logic       x_at_left,
  input wire logic       x_at_right
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // command checks assume the driver spaces commands wider than the 6-edge latency
  property p_y_hold; $changed(y_dac_code) |-> y_update && y_dac_code == $past(y_word); endproperty
  a_y_hold: assert property (p_y_hold) else $error("vertical code moved without a capture");
  property p_up;
    $rose(x_step_up) && !x_step_down && !x_preset_full && !x_return_left |->
      ##6 x_dac_code == $past(x_dac_code, 6) + 10'h001;
  endproperty
  a_up: assert property (p_up) else $error("step up did not add one");
  property p_down;
    $rose(x_step_down) && !x_step_up && !x_preset_full && !x_return_left |->
      ##6 x_dac_code == $past(x_dac_code, 6) - 10'h001;
  endproperty
  a_down: assert property (p_down) else $error("step down did not subtract one");
  property p_preset; $rose(x_preset_full) && !x_return_left |-> ##6 x_dac_code == 10'h3FF; endproperty
  a_preset: assert property (p_preset) else $error("preset missed far right");
  property p_clear; $rose(x_return_left) |-> ##6 x_dac_code == 10'h000; endproperty
  a_clear: assert property (p_clear) else $error("return left missed far left");
  property p_follow; x_update == $changed(x_dac_code); endproperty
  a_follow: assert property (p_follow) else $error("horizontal change not flagged");
  property p_ends;
    x_at_left == (x_dac_code == 10'h000) && x_at_right == (x_dac_code == 10'h3FF);
  endproperty
  a_ends: assert property (p_ends) else $error("end flags disagree with code");
  property p_prio; $rose(x_preset_full) && $rose(x_step_up) && !x_return_left |-> ##6 x_at_right; endproperty
  a_prio: assert property (p_prio) else $error("count beat preset");
endmodule : xy_plotter_axis_drive_monitor

bind xy_plotter_axis_drive xy_plotter_axis_drive_monitor i_mon (.core_clk(core_clk), .srst(srst),
  .y_word(y_word), .y_strobe(y_strobe), .x_step_up(x_step_up), .x_step_down(x_step_down),
  .x_preset_full(x_preset_full), .x_return_left(x_return_left), .y_dac_code(y_dac_code),
  .x_dac_code(x_dac_code), .y_update(y_update), .x_update(x_update), .x_at_left(x_at_left),
  .x_at_right(x_at_right));

//--- verification/xy_display_driver_model.sv
`timescale 1ns/1ps
module xy_display_driver_model (
  // clock
  input wire logic core_clk,
  // strobes and data to the plotter front end
  output logic [9:0] y_word,
  output logic       y_strobe,
  output logic       x_step_up,
  output logic       x_step_down,
  output logic       x_preset_full,
  output logic       x_return_left
);
  initial {y_word, x_return_left, x_preset_full, x_step_down, x_step_up, y_strobe} = 15'h0000;
  // word settles a cycle early; strobes stay 4 high and 6 low between sends, beyond the 2-cycle minimum
  task automatic send(input logic [4:0] m, input logic [9:0] w);
    y_word = w;
    @(negedge core_clk);
    {x_return_left, x_preset_full, x_step_down, x_step_up, y_strobe} = m;
    repeat (4) @(negedge core_clk);
    {x_return_left, x_preset_full, x_step_down, x_step_up, y_strobe} = 5'h00;
    repeat (2) @(negedge core_clk);
    // hold window over: word no longer trustworthy
    y_word = ~w;
    repeat (3) @(negedge core_clk);
  endtask : send
endmodule : xy_display_driver_model

//--- verification/tb_xy_plotter_axis_drive.sv
`timescale 1ns/1ps
module tb_xy_plotter_axis_drive;
  logic        core_clk = 1'b0;
  logic        srst     = 1'b1;
  logic [9:0]  y_word, y_dac_code, x_dac_code, xm, e;
  logic        y_strobe, x_step_up, x_step_down, x_preset_full, x_return_left;
  logic        y_update, x_update, x_at_left, x_at_right;
  logic [9:0]  yq[$], xq[$];
  logic [31:0] rnd = 32'h51A677AB;
  int          err_total  = 0;
  int          n_compared = 0;
  initial forever #20 core_clk = ~core_clk;
  xy_plotter_axis_drive i_dut (.core_clk(core_clk), .srst(srst), .y_word(y_word), .y_strobe(y_strobe),
    .x_step_up(x_step_up), .x_step_down(x_step_down), .x_preset_full(x_preset_full),
    .x_return_left(x_return_left), .y_dac_code(y_dac_code), .x_dac_code(x_dac_code),
    .y_update(y_update), .x_update(x_update), .x_at_left(x_at_left), .x_at_right(x_at_right));
  xy_display_driver_model i_drv (.core_clk(core_clk), .y_word(y_word), .y_strobe(y_strobe),
    .x_step_up(x_step_up), .x_step_down(x_step_down), .x_preset_full(x_preset_full),
    .x_return_left(x_return_left));
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // mask order: return left, preset, down, up, vertical strobe
  task automatic op(input logic [4:0] m, input logic [9:0] w);
    logic [9:0] n;
    n = m[4] ? xy_plotter_pkg::X_LEFT_CODE : m[3] ? xy_plotter_pkg::X_RIGHT_CODE :
        (m[1] && !m[2]) ? xm + xy_plotter_pkg::X_STEP : (m[2] && !m[1]) ? xm - xy_plotter_pkg::X_STEP : xm;
    if (n !== xm) xq.push_back(n);
    if (m[0]) yq.push_back(w);
    xm = n;
    i_drv.send(m, w);
  endtask : op
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  always @(negedge core_clk) begin
    if (y_update === 1'b1) begin
      e = yq.size() ? yq.pop_front() : ~y_dac_code;
      chk("y_dac_code", e, y_dac_code);
    end
    if (x_update === 1'b1) begin
      e = xq.size() ? xq.pop_front() : ~x_dac_code;
      chk("x_dac_code", e, x_dac_code);
      chk("x_at_left", {9'h000, e == 10'h000}, {9'h000, x_at_left});
      chk("x_at_right", {9'h000, e == 10'h3FF}, {9'h000, x_at_right});
    end
  end
  initial begin
    xm = xy_plotter_pkg::X_RESET_CODE;
    repeat (12) @(negedge core_clk);
    srst = 1'b0;
    chk("x_at_left", 10'h001, {9'h000, x_at_left});
    chk("y_dac_code", 10'h000, y_dac_code);
    $display("reset test done");
    op(5'h04, 10'h155);
    op(5'h03, 10'h2AA);
    op(5'h02, 10'h000);
    op(5'h05, 10'h3FF);
    op(5'h08, 10'h001);
    op(5'h10, 10'h000);
    op(5'h0A, 10'h000);
    op(5'h1D, 10'h200);
    op(5'h06, 10'h000);
    $display("directed test done");
    repeat (24) begin
      rnd = lfsr_next(rnd);
      op(rnd[4:0], rnd[14:5]);
    end
    repeat (10) @(negedge core_clk);
    chk("pending", 10'h000, 10'(xq.size() + yq.size()));
    $display("random test done");
    report_and_stop();
  end
  initial begin
    #60000;
    err_total++;
    report_and_stop();
  end
endmodule : tb_xy_plotter_axis_drive
